/* ctrl_cpu_model.sv */
// Controller CPU model that turns word requests from the bench into APB transfers.
`timescale 1ns/1ns
module ctrl_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   output logic done,
   output logic [31:0] rdata,
   output logic err,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // Released address and data are inverted so a slave that samples them late sees garbage, not a stale match.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {done, err, psel, penable, pwrite} <= 5'h00;
         {rdata, paddr, pwdata} <= 72'h0;
      end else begin
         done <= 1'b0;
         if (!psel && req && !done) begin
            psel <= 1'b1;
            pwrite <= we;
            paddr <= addr;
            pwdata <= wdata;
         end else if (psel && !penable) begin
            penable <= 1'b1;
         end else if (psel && pready) begin
            rdata <= prdata;
            err <= pslverr;
            done <= 1'b1;
            {psel, penable} <= 2'h0;
            paddr <= ~paddr;
            pwdata <= ~pwdata;
         end
      end
   end
endmodule : ctrl_cpu_model

/* tc_cfg_pkg.sv */
// Shared constants, types and limit functions of the thermocouple input block.
package tc_cfg_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int UPDATE_PERIOD_MS = 405;
   localparam int UPDATE_CYCLES = UPDATE_PERIOD_MS * (CLK_HZ / 1000);
   localparam int SYNC_FILL_CYCLES = 2;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_DATA0 = 8'h10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_PUBLISH_BIT = 1;
   localparam int CFG_LOADED_BIT = 8;
   localparam int STAT_SUPPLY_BIT = 2;
   localparam int STAT_RANGE_BIT = 3;
   localparam int STAT_OPEN_LSB = 8;
   localparam logic [2:0] TYPE_J = 3'h0;
   localparam logic [2:0] TYPE_K = 3'h1;
   localparam logic [2:0] TYPE_T = 3'h2;
   localparam logic [2:0] TYPE_E = 3'h3;
   localparam logic [2:0] TYPE_R = 3'h4;
   localparam logic [2:0] TYPE_S = 3'h5;
   localparam logic [2:0] TYPE_N = 3'h6;
   localparam logic [2:0] TYPE_MV = 3'h7;
   localparam int OPEN_WIRE_UV = 200000;
   localparam int FULL_SCALE_UV = 80000;
   localparam int FULL_SCALE_CODE = 27648;
   localparam int MV_OVER_CODE = 32511;
   localparam int MV_UNDER_CODE = -32512;
   localparam logic signed [15:0] CODE_MAX = 16'sh7fff;
   localparam logic signed [15:0] CODE_MIN = 16'sh8000;
   localparam logic signed [15:0] CODE_NO_SUPPLY = 16'sh7ffe;
   localparam longint MV_GAIN_Q16 = (longint'(FULL_SCALE_CODE) * 65536) / FULL_SCALE_UV;
   localparam int F_GAIN_Q16 = (9 * 65536) / 5;
   localparam int F_OFFSET_DC = 320;

   typedef struct packed {
      logic ref_junction_comp_disable;
      logic fahrenheit_select;
      logic open_wire_current_disable;
      logic open_wire_direction_sel;
      logic reserved;
      logic [2:0] tc_type;
   } cfg_type;

   function automatic int high_limit_dc(input logic [2:0] t);
      case (t)
         TYPE_J: high_limit_dc = 12000;
         TYPE_K: high_limit_dc = 13720;
         TYPE_T: high_limit_dc = 4000;
         TYPE_E: high_limit_dc = 10000;
         TYPE_N: high_limit_dc = 13000;
         default: high_limit_dc = 17680;
      endcase
   endfunction : high_limit_dc

   function automatic int low_limit_dc(input logic [2:0] t);
      case (t)
         TYPE_J: low_limit_dc = -2100;
         TYPE_R, TYPE_S: low_limit_dc = -500;
         default: low_limit_dc = -2700;
      endcase
   endfunction : low_limit_dc
endpackage : tc_cfg_pkg

/* tc_channel_math.sv */
// One-cycle conversion pipeline from a raw channel voltage to a 16-bit data word.
`timescale 1ns/1ns
module tc_channel_math #(
   parameter int SEEBECK_Q16 = 268698,
   parameter int RECIP_Q16 = 15984
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic in_valid,
   input wire logic signed [19:0] in_uv,
   input wire logic signed [11:0] cj_dc,
   input wire tc_cfg_pkg::cfg_type cfg,
   output logic out_valid,
   output logic signed [15:0] out_code,
   output logic out_range_err,
   output logic out_open_wire
);
   import tc_cfg_pkg::*;
   logic mv_mode;
   logic cjc_on;
   logic open_wire;
   logic signed [47:0] corr_uv;
   logic signed [47:0] lin_dc;
   logic signed [47:0] mv_code;
   logic signed [47:0] f_dc;
   logic signed [15:0] code_next;
   logic err_next;

   always_comb begin
      mv_mode = (cfg.tc_type == TYPE_MV);
      cjc_on = !cfg.ref_junction_comp_disable && !mv_mode;
      // The range check runs whatever the current source setting is.
      open_wire = (in_uv > OPEN_WIRE_UV) || (in_uv < -OPEN_WIRE_UV);
      corr_uv = cjc_on ? (48'(cj_dc) * SEEBECK_Q16) >>> 16 : '0;
      // A single gain stands in for the per-type table, which lives outside this block.
      lin_dc = ((48'(in_uv) + corr_uv) * RECIP_Q16) >>> 16;
      // Rounding to nearest keeps full scale at exactly 27648 although the gain itself is truncated.
      mv_code = 48'((48'(in_uv) * MV_GAIN_Q16 + 64'sh8000) >>> 16);
      f_dc = ((lin_dc * F_GAIN_Q16) >>> 16) + F_OFFSET_DC;
      err_next = 1'b1;
      if (open_wire) begin
         code_next = cfg.open_wire_direction_sel ? CODE_MIN : CODE_MAX;
      end else if (mv_mode) begin
         if (mv_code > MV_OVER_CODE) begin
            code_next = CODE_MAX;
         end else if (mv_code < MV_UNDER_CODE) begin
            code_next = CODE_MIN;
         end else begin
            code_next = 16'(mv_code);
            err_next = 1'b0;
         end
      end else if (lin_dc > high_limit_dc(cfg.tc_type)) begin
         code_next = CODE_MAX;
      end else if (lin_dc < low_limit_dc(cfg.tc_type)) begin
         code_next = CODE_MIN;
      end else begin
         code_next = cfg.fahrenheit_select ? 16'(f_dc) : 16'(lin_dc);
         err_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_code <= '0;
         out_range_err <= 1'b0;
         out_open_wire <= 1'b0;
      end else begin
         out_valid <= in_valid;
         if (in_valid) begin
            out_code <= code_next;
            out_range_err <= err_next;
            out_open_wire <= open_wire;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_open_wire_code;
      in_valid && open_wire |=> out_open_wire && out_range_err &&
         (out_code == ($past(cfg.open_wire_direction_sel) ? CODE_MIN : CODE_MAX));
   endproperty
   a_open_wire_code: assert property (p_open_wire_code) else $error("open wire code wrong");

   property p_range_always;
      in_valid && cfg.open_wire_current_disable && ((in_uv > OPEN_WIRE_UV) || (in_uv < -OPEN_WIRE_UV))
         |=> out_open_wire;
   endproperty
   a_range_always: assert property (p_range_always) else $error("open wire missed with source off");

   property p_mv_no_cjc;
      in_valid && (cfg.tc_type == TYPE_MV) && (in_uv == -20'sh0ea60) |=> out_code == 16'shaf00;
   endproperty
   a_mv_no_cjc: assert property (p_mv_no_cjc) else $error("compensation active in mV mode");

   property p_mv_full_scale;
      in_valid && (cfg.tc_type == TYPE_MV) && (in_uv == FULL_SCALE_UV) |=> out_code == 16'sh6c00;
   endproperty
   a_mv_full_scale: assert property (p_mv_full_scale) else $error("mV full scale not 27648");

   property p_saturate;
      out_valid && out_range_err && !out_open_wire |-> (out_code == CODE_MAX) || (out_code == CODE_MIN);
   endproperty
   a_saturate: assert property (p_saturate) else $error("range error without saturation");
endmodule : tc_channel_math

/* test_thermocouple_input_config.sv */
// Self-checking testbench of the thermocouple input block.
`timescale 1ns/1ns
module test_thermocouple_input_config;
   import tc_cfg_pkg::*;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
   logic pclk, presetn, req, we, done, err, psel, penable, pwrite, pready, pslverr;
   logic [7:0] addr, paddr, config_switches;
   logic [31:0] wdata, rdata, pwdata, prdata;
   logic user_supply_ok, conv_valid, open_wire_current_en, range_error, supply_bad;
   logic [1:0] conv_chan;
   logic signed [19:0] conv_uv;
   logic signed [11:0] cj_temp_dc;
   int n_fail = 0;
   int samples_checked = 0;
   ctrl_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .req(req), .we(we), .addr(addr), .wdata(wdata),
      .done(done), .rdata(rdata), .err(err), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   thermocouple_input_config #(.NUM_CHANNELS(4), .UPDATE_CYCLES(50)) i_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .config_switches(config_switches), .user_supply_ok(user_supply_ok),
      .conv_valid(conv_valid), .conv_chan(conv_chan), .conv_uv(conv_uv), .cj_temp_dc(cj_temp_dc),
      .open_wire_current_en(open_wire_current_en), .range_error(range_error), .supply_bad(supply_bad));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= v;
      do @(negedge pclk); while (done !== 1'b1);
      @(posedge pclk);
      req <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, exp)
   endtask : rd
   // Reserved switch bit stays 0 in every setting the bench makes.
   function automatic logic [7:0] sw(input logic [2:0] t, input logic dir, cur, fahr, cjc);
      return {cjc, fahr, cur, dir, 1'b0, t[0], t[1], t[2]};
   endfunction : sw
   task automatic rst(input logic [7:0] s, input logic sup);
      presetn <= 1'b0;
      config_switches <= s;
      user_supply_ok <= sup;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(ADDR_CTRL, CTRL_RESET);
      apb(1'b1, ADDR_CTRL, 32'h0);
   endtask : rst
   task automatic conv(input logic [1:0] c, input logic signed [19:0] uv, input logic signed [11:0] cj);
      @(posedge pclk);
      conv_valid <= 1'b1;
      conv_chan <= c;
      conv_uv <= uv;
      cj_temp_dc <= cj;
      @(posedge pclk);
      conv_valid <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask : conv
   task automatic t_cfg();
      for (int t = 0; t < 8; t++) begin
         rst(sw(3'(t), 1'b1, 1'b1, 1'b0, 1'b1), 1'b1);
         rd(ADDR_CONFIG, {24'h1, 5'h16, 3'(t)});
         `CHK(open_wire_current_en, 1'b0)
         config_switches <= 8'h00;
         repeat (4) @(posedge pclk);
         rd(ADDR_CONFIG, {24'h1, 5'h16, 3'(t)});
      end
      apb(1'b0, 8'h20, 32'h0);
      `CHK(err, 1'b1)
   endtask : t_cfg
   task automatic t_temp();
      // Compensation stays on because real thermocouples are assumed wired.
      rst(sw(TYPE_K, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      `CHK(open_wire_current_en, 1'b1)
      conv(2'h0, 20'sd0, 12'sd250);
      conv(2'h1, 20'sd60000, 12'sd0);
      conv(2'h2, 20'sd250000, 12'sd0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_COUNT, 32'h1);
      conv(2'h0, 20'sd0, 12'sd0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_COUNT, 32'h1);
      rd(ADDR_DATA0, 32'd249);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_DATA0, 32'd0);
      rd(ADDR_DATA0 + 8'h4, 32'd32767);
      rd(ADDR_DATA0 + 8'h8, 32'd32767);
      rd(ADDR_STATUS, 32'h408);
      `CHK(range_error, 1'b1)
   endtask : t_temp
   task automatic t_fahr();
      rst(sw(TYPE_K, 1'b0, 1'b0, 1'b1, 1'b1), 1'b1);
      conv(2'h0, 20'sd0, 12'sd250);
      conv(2'h1, 20'sd4100, 12'sd250);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_DATA0, 32'd320);
      rd(ADDR_DATA0 + 8'h4, 32'd2118);
   endtask : t_fahr
   task automatic t_mv();
      rst(sw(TYPE_MV, 1'b1, 1'b1, 1'b0, 1'b0), 1'b1);
      conv(2'h0, -20'sd60000, 12'sd250);
      conv(2'h1, 20'sd95000, 12'sd0);
      conv(2'h2, -20'sd250000, 12'sd0);
      conv(2'h3, 20'sd80000, 12'sd0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_DATA0, 32'hffff_af00);
      rd(ADDR_DATA0 + 8'hc, 32'h6c00);
      rd(ADDR_DATA0 + 8'h4, 32'd32767);
      rd(ADDR_DATA0 + 8'h8, 32'hffff_8000);
   endtask : t_mv
   task automatic t_supply();
      rst(sw(TYPE_J, 1'b0, 1'b0, 1'b0, 1'b0), 1'b0);
      conv(2'h0, 20'sd0, 12'sd0);
      apb(1'b1, ADDR_CTRL, 32'h2);
      rd(ADDR_DATA0, 32'd32766);
      apb(1'b0, ADDR_STATUS, 32'h0);
      `CHK(rdata[3:2], 2'h1)
      `CHK({supply_bad, range_error}, 2'h2)
   endtask : t_supply
   // Periodic refresh: one tick publishes, the next is skipped while data stays unread.
   task automatic t_tick();
      rst(sw(TYPE_J, 1'b0, 1'b0, 1'b0, 1'b0), 1'b1);
      apb(1'b1, ADDR_CTRL, 32'h1);
      conv(2'h3, 20'sh0, 12'sh0fa);
      repeat (55) @(posedge pclk);
      rd(ADDR_COUNT, 32'h1);
      repeat (55) @(posedge pclk);
      rd(ADDR_COUNT, 32'h1);
      rd(ADDR_DATA0 + 8'hc, 32'hf9);
      repeat (55) @(posedge pclk);
      rd(ADDR_COUNT, 32'h2);
   endtask : t_tick
   initial begin
      {presetn, req, we, conv_valid, user_supply_ok} = 5'h01;
      {addr, config_switches, conv_chan} = 18'h0;
      {wdata, conv_uv, cj_temp_dc} = 64'h0;
      t_cfg();
      t_temp();
      t_fahr();
      t_mv();
      t_supply();
      t_tick();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      conclude();
   end
endmodule : test_thermocouple_input_config

/* thermocouple_input_config.sv */
// Configuration latch, conversion scheduling, result publishing and APB registers of the thermocouple input.
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ns
// Operation
// - Switches are sampled only at power-up; later changes wait for the next reset.
// - Three type bits pick J, K, T, E, R, S, N or millivolt for all channels.
// - Direction switch picks upscale 32767 or downscale -32768 as the open-wire reading.
// - Open-wire current source is on when its switch is 0, off when 1.
// - The open-wire range check runs on every conversion, source on or off.
// - Inputs beyond about 200 mV declare open wire and substitute the direction value.
// - Scale switch reports Celsius at 0, Fahrenheit at 1, converted inside.
// - Reference-junction compensation is enabled at 0 and disabled at 1.
// - Millivolt mode always turns reference-junction compensation off.
// - Module temperature becomes a correction added before linearisation.
// - Results are 16-bit two's complement, 0.1 degree units, millivolt full scale 27648.
// - Error status bit 3 flags range error, bit 2 flags missing user supply.
// - Over and under range saturate to 32767 and -32768 unless open wire.
// - Channels refresh every 405 ms only after the previous data was read.
module thermocouple_input_config #(
   parameter int NUM_CHANNELS = 4,
   parameter int UPDATE_CYCLES = tc_cfg_pkg::UPDATE_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] config_switches,
   input wire logic user_supply_ok,
   input wire logic conv_valid,
   input wire logic [1:0] conv_chan,
   input wire logic signed [19:0] conv_uv,
   input wire logic signed [11:0] cj_temp_dc,
   output logic open_wire_current_en,
   output logic range_error,
   output logic supply_bad
);
   import tc_cfg_pkg::*;

   localparam int CW = $clog2(NUM_CHANNELS);

   logic [7:0] sw_meta_reg;
   logic [7:0] sw_sync_reg;
   logic sup_meta_reg;
   logic sup_sync_reg;
   logic [1:0] load_cnt_reg;
   logic cfg_loaded_reg;
   cfg_type cfg_reg;
   cfg_type cfg_next;
   logic [31:0] ctrl_reg;
   logic [31:0] tick_cnt_reg;
   logic tick;
   logic publish;
   logic data_read_reg;
   logic [CW-1:0] chan_pipe_reg;
   logic math_in_valid;
   logic math_valid;
   logic signed [15:0] math_code;
   logic math_err;
   logic math_open;
   logic signed [15:0] shadow_reg [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] shadow_err_reg;
   logic [NUM_CHANNELS-1:0] shadow_open_reg;
   logic signed [15:0] data_reg [NUM_CHANNELS];
   logic [NUM_CHANNELS-1:0] open_reg;
   logic [31:0] publish_count_reg;
   logic apb_setup;
   logic apb_done;
   logic apb_rd_data;
   logic [31:0] rdata_next;
   logic err_next;

   function automatic logic is_data_addr(input logic [7:0] a);
      is_data_addr = (a >= ADDR_DATA0) && (a < ADDR_DATA0 + 8'(4 * NUM_CHANNELS)) && (a[1:0] == 2'h0);
   endfunction : is_data_addr

   function automatic logic [CW-1:0] data_index(input logic [7:0] a);
      logic [7:0] off;
      off = a - ADDR_DATA0;
      data_index = CW'(off[7:2]);
   endfunction : data_index

   // Pins are asynchronous to pclk, so both pass a two-stage synchroniser.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_meta_reg <= '0;
         sw_sync_reg <= '0;
         sup_meta_reg <= 1'b0;
         sup_sync_reg <= 1'b0;
      end else begin
         sw_meta_reg <= config_switches;
         sw_sync_reg <= sw_meta_reg;
         sup_meta_reg <= user_supply_ok;
         sup_sync_reg <= sup_meta_reg;
      end
   end

   // Switch 1 is the most significant type bit, so type E reads 0, 1, 1 on switches 1 to 3.
   always_comb begin
      cfg_next.ref_junction_comp_disable = sw_sync_reg[7];
      cfg_next.fahrenheit_select = sw_sync_reg[6];
      cfg_next.open_wire_current_disable = sw_sync_reg[5];
      cfg_next.open_wire_direction_sel = sw_sync_reg[4];
      cfg_next.reserved = sw_sync_reg[3];
      cfg_next.tc_type = {sw_sync_reg[0], sw_sync_reg[1], sw_sync_reg[2]};
   end

   // The switches are read once, after the synchroniser has filled, and never again.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_cnt_reg <= '0;
         cfg_loaded_reg <= 1'b0;
         cfg_reg <= '0;
      end else if (!cfg_loaded_reg) begin
         if (load_cnt_reg == 2'(SYNC_FILL_CYCLES)) begin
            cfg_loaded_reg <= 1'b1;
            cfg_reg <= cfg_next;
         end else begin
            load_cnt_reg <= load_cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_wire_current_en <= 1'b0;
      end else begin
         open_wire_current_en <= cfg_loaded_reg && !cfg_reg.open_wire_current_disable;
      end
   end

   // Conversions are ignored until the configuration is known.
   assign math_in_valid = conv_valid && cfg_loaded_reg && (32'(conv_chan) < NUM_CHANNELS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_pipe_reg <= '0;
      end else if (math_in_valid) begin
         chan_pipe_reg <= CW'(conv_chan);
      end
   end

   tc_channel_math u_math (
      .pclk(pclk),
      .presetn(presetn),
      .in_valid(math_in_valid),
      .in_uv(conv_uv),
      .cj_dc(cj_temp_dc),
      .cfg(cfg_reg),
      .out_valid(math_valid),
      .out_code(math_code),
      .out_range_err(math_err),
      .out_open_wire(math_open)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            shadow_reg[i] <= '0;
         end
         shadow_err_reg <= '0;
         shadow_open_reg <= '0;
      end else if (math_valid) begin
         shadow_reg[chan_pipe_reg] <= math_code;
         shadow_err_reg[chan_pipe_reg] <= math_err;
         shadow_open_reg[chan_pipe_reg] <= math_open;
      end
   end

   // Update period divider; a one-cycle tick drives the refresh.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_reg <= '0;
      end else if (!ctrl_reg[CTRL_RUN_BIT] || tick) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
      end
   end

   assign tick = ctrl_reg[CTRL_RUN_BIT] && (tick_cnt_reg == 32'(UPDATE_CYCLES - 1));
   assign publish = (tick || (apb_done && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_PUBLISH_BIT]))
      && data_read_reg && cfg_loaded_reg;

   // A read in the same cycle as a refresh is kept, so the next refresh is not lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_read_reg <= 1'b1;
      end else if (apb_rd_data) begin
         data_read_reg <= 1'b1;
      end else if (publish) begin
         data_read_reg <= 1'b0;
      end
   end

   // Without user supply every channel shows the fixed no-supply code.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            data_reg[i] <= '0;
         end
         open_reg <= '0;
         range_error <= 1'b0;
         publish_count_reg <= '0;
      end else if (publish) begin
         for (int i = 0; i < NUM_CHANNELS; i++) begin
            data_reg[i] <= sup_sync_reg ? shadow_reg[i] : CODE_NO_SUPPLY;
         end
         open_reg <= sup_sync_reg ? shadow_open_reg : '0;
         range_error <= sup_sync_reg && (|shadow_err_reg);
         publish_count_reg <= publish_count_reg + 32'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         supply_bad <= 1'b0;
      end else begin
         supply_bad <= !sup_sync_reg;
      end
   end

   // APB slave with one wait-free access phase; pready is a flop so it rises in the access cycle.
   assign apb_setup = psel && !penable && !pready;
   assign apb_done = psel && penable && pready;
   assign apb_rd_data = apb_done && !pwrite && is_data_addr(paddr);

   always_comb begin
      rdata_next = '0;
      err_next = 1'b0;
      if (is_data_addr(paddr)) begin
         rdata_next = {{16{data_reg[data_index(paddr)][15]}}, data_reg[data_index(paddr)]};
      end else begin
         case (paddr)
            ADDR_CTRL: begin
               rdata_next = ctrl_reg;
            end
            ADDR_CONFIG: begin
               rdata_next[7:0] = cfg_reg;
               rdata_next[CFG_LOADED_BIT] = cfg_loaded_reg;
            end
            ADDR_STATUS: begin
               rdata_next[STAT_RANGE_BIT] = range_error;
               rdata_next[STAT_SUPPLY_BIT] = supply_bad;
               rdata_next[STAT_OPEN_LSB +: NUM_CHANNELS] = open_reg;
            end
            ADDR_COUNT: begin
               rdata_next = publish_count_reg;
            end
            default: begin
               err_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (apb_setup) begin
         pready <= 1'b1;
         pslverr <= err_next;
         prdata <= pwrite ? 32'h0 : rdata_next;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // The publish bit is a strobe and never stays set in the register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (apb_done && pwrite && (paddr == ADDR_CTRL)) begin
         ctrl_reg <= {31'h0, pwdata[CTRL_RUN_BIT]};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_cfg_frozen;
      cfg_loaded_reg |=> cfg_loaded_reg && $stable(cfg_reg);
   endproperty
   a_cfg_frozen: assert property (p_cfg_frozen) else $error("configuration changed after load");

   sequence s_load_fill;
      !cfg_loaded_reg ##1 !cfg_loaded_reg ##1 !cfg_loaded_reg;
   endsequence
   property p_load_once;
      $rose(presetn) |-> s_load_fill ##1 cfg_loaded_reg;
   endproperty
   a_load_once: assert property (@(posedge pclk) p_load_once) else $error("config not latched on time");

   property p_type_map;
      $rose(cfg_loaded_reg) |-> cfg_reg.tc_type == {$past(sw_sync_reg[0]), $past(sw_sync_reg[1]), $past(sw_sync_reg[2])};
   endproperty
   a_type_map: assert property (p_type_map) else $error("type bits mapped wrongly");

   property p_current_src;
      cfg_loaded_reg ##1 cfg_loaded_reg |-> open_wire_current_en == !cfg_reg.open_wire_current_disable;
   endproperty
   a_current_src: assert property (p_current_src) else $error("current source enable wrong");

   property p_stale_hold;
      tick && !data_read_reg |=> $stable(publish_count_reg) && (data_reg[0] == $past(data_reg[0]));
   endproperty
   a_stale_hold: assert property (p_stale_hold) else $error("unread data replaced");

   property p_refresh;
      tick && data_read_reg && cfg_loaded_reg |=> publish_count_reg == $past(publish_count_reg) + 32'h1;
   endproperty
   a_refresh: assert property (p_refresh) else $error("read data not refreshed on tick");

   property p_supply_bit;
      !sup_sync_reg |=> supply_bad;
   endproperty
   a_supply_bit: assert property (p_supply_bit) else $error("supply bad flag missing");

   property p_status_read;
      apb_setup && !pwrite && (paddr == ADDR_STATUS) |=> pready && (prdata[STAT_RANGE_BIT] == $past(range_error));
   endproperty
   a_status_read: assert property (p_status_read) else $error("status read wrong");

   property p_strobe_unread;
      apb_done && pwrite && (paddr == ADDR_CTRL) && pwdata[CTRL_PUBLISH_BIT] && !data_read_reg
         |=> $stable(publish_count_reg);
   endproperty
   a_strobe_unread: assert property (p_strobe_unread) else $error("unread data published by strobe");

   property p_read_wins;
      apb_rd_data |=> data_read_reg;
   endproperty
   a_read_wins: assert property (p_read_wins) else $error("data read flag lost");

   property p_no_supply_data;
      publish && !sup_sync_reg |=> (data_reg[0] == CODE_NO_SUPPLY) && !range_error;
   endproperty
   a_no_supply_data: assert property (p_no_supply_data) else $error("no-supply code missing");
endmodule : thermocouple_input_config
